// File: design/sensor_fault_status.sv
// The register offsets and register access over Wishbone were left to the implementer.
`include "sensor_fault_defines.svh"

// Operation
// - Error response on an I2C-port access sets the I2C access error flag.
// - Error response on a single-wire-port access sets the single-wire access flag.
// - Error response on a trace queue access sets the trace queue flag.
// - Sync field slower than 320 bits per second raises the slow-sync flag.
// - Sync field faster than 9600 bits per second raises the fast-sync flag.
// - Sync stop bit shorter than the minimum raises a flag.
// - Command stop bit at the wrong level raises a flag.
// - Command stop bit shorter than the minimum raises a flag.
// - Host data stop bit at the wrong level raises a flag.
// - Host data stop bit shorter than the minimum raises a flag.
// - Host pulling the line low during our data stop bit sets override.
// - Consecutive sync bit periods differing over 25 percent raise a tolerance flag.
// - A received command that is not supported sets the invalid command flag.
// - Bridge supply high above 1.15, low below 0.85 of nominal.
// - Reference high above 1.1, low at 0.9 of nominal.
// - Core supply high above 1.15, low below 0.9 of nominal.
// - Pressure input high and low flags cover either input pin.
// - Temperature input high and low flags cover either input pin.
// - Pressure amplifier output has its own high and low flags.
// - Temperature amplifier output has its own high and low flags.
// - Front-end flags set only while their own stored enable or the global enable is set.
// - One global enable turns on every front-end check at once.
module sensor_fault_status #(
	parameter int SYNC_SLOW_CYCLES = `SYNC_SLOW_CYCLES,
	parameter int SYNC_FAST_CYCLES = `SYNC_FAST_CYCLES,
	parameter int STOP_MIN_CYCLES  = `STOP_MIN_CYCLES
) (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Wishbone slave
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [7:0]                     wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [31:0]                    wb_dat_i,
	output logic      [31:0]                    wb_dat_o,
	output logic                                wb_ack_o,
	// Internal access error responses
	input  wire logic                           i2cErrResp,
	input  wire logic                           swireErrResp,
	input  wire logic                           traceErrResp,
	// Single-wire receiver view
	input  wire logic                           swireLine,
	input  wire sensor_fault_pkg::swire_phase_e swirePhase,
	input  wire logic                           swireDeviceTx,
	input  wire logic                           swireCmdDone,
	input  wire logic                           swireCmdValid,
	// Supply comparators
	input  wire logic                           bridgeSupplyHigh,
	input  wire logic                           bridgeSupplyLow,
	input  wire logic                           referenceHigh,
	input  wire logic                           referenceLow,
	input  wire logic                           coreSupplyHigh,
	input  wire logic                           coreSupplyLow,
	// Front-end comparators, one per pin
	input  wire logic                           pressureInputPosHigh,
	input  wire logic                           pressureInputNegHigh,
	input  wire logic                           pressureInputPosLow,
	input  wire logic                           pressureInputNegLow,
	input  wire logic                           temperatureInputPosHigh,
	input  wire logic                           temperatureInputNegHigh,
	input  wire logic                           temperatureInputPosLow,
	input  wire logic                           temperatureInputNegLow,
	input  wire logic                           pressureAmpOutHigh,
	input  wire logic                           pressureAmpOutLow,
	input  wire logic                           temperatureAmpOutHigh,
	input  wire logic                           temperatureAmpOutLow,
	// Summary
	output logic                                anyFault
);
	localparam sensor_fault_pkg::swire_phase_e STOP_PHASES [3] = '{
		sensor_fault_pkg::PH_SYNC_STOP,
		sensor_fault_pkg::PH_CMD_STOP,
		sensor_fault_pkg::PH_DATA_STOP
	};

	// Expand byte enables into a bit mask
	function automatic logic [31:0] byteMask(input logic [3:0] sel);
		byteMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	swire_if link ();

	logic [`IFACE_W-1:0]   ifaceErr_reg, ifaceErr_next, ifaceSet;
	logic [`SWIRE_W-1:0]   swireErr_reg, swireErr_next, swireSet;
	logic [`SUPPLY_W-1:0]  supplyMonitorFlags_reg, supplyMonitorFlags_next, supplySet;
	logic [`FRONT_W-1:0]   frontEndDiagFlags_reg, frontEndDiagFlags_next, frontSet;
	logic [`FRONT_W-1:0]   frontCmp, frontEnable;
	logic [`DIAG_EN_W-1:0] diagEnable_reg, diagEnable_next;
	logic [31:0]           datNext, wrMask, readWord;
	logic                  ackNext, busHit, wrNow, anyNext;
	logic                  slowErr, fastErr, tolErr;
	logic [2:0]            stopBad, stopShort, stopOver;

	// Receiver signals gathered for the checkers
	assign link.lineLevel = swireLine;
	assign link.phase     = swirePhase;
	assign link.deviceTx  = swireDeviceTx;

	sync_rate_checker #(
		.SLOW_CYCLES (SYNC_SLOW_CYCLES),
		.FAST_CYCLES (SYNC_FAST_CYCLES),
		.CNT_W       (20)
	) syncCheck (
		.clock   (clock),
		.rst_n   (rst_n),
		.link    (link.monitor),
		.slowErr (slowErr),
		.fastErr (fastErr),
		.tolErr  (tolErr)
	);

	// One stop checker per stop bit kind: sync, command, data
	for (genvar i = 0; i < 3; i++) begin : gStop
		stop_bit_checker #(
			.STOP_PHASE (STOP_PHASES[i]),
			.MIN_CYCLES (STOP_MIN_CYCLES),
			.CNT_W      (20)
		) stopCheck (
			.clock      (clock),
			.rst_n      (rst_n),
			.link       (link.monitor),
			.badLevel   (stopBad[i]),
			.shortStop  (stopShort[i]),
			.overdriven (stopOver[i])
		);
	end

	// Events that set flags this cycle
	always_comb begin
		ifaceSet = '0;
		ifaceSet[`IFACE_I2C_BIT]   = i2cErrResp;
		ifaceSet[`IFACE_SWIRE_BIT] = swireErrResp;
		ifaceSet[`IFACE_TRACE_BIT] = traceErrResp;
		swireSet = '0;
		swireSet[`SW_SYNC_SLOW_BIT]  = slowErr;
		swireSet[`SW_SYNC_FAST_BIT]  = fastErr;
		swireSet[`SW_SYNC_SHORT_BIT] = stopShort[0];
		swireSet[`SW_CMD_BAD_BIT]    = stopBad[1];
		swireSet[`SW_CMD_SHORT_BIT]  = stopShort[1];
		swireSet[`SW_DATA_BAD_BIT]   = stopBad[2];
		swireSet[`SW_DATA_SHORT_BIT] = stopShort[2];
		swireSet[`SW_DATA_OVER_BIT]  = stopOver[2];
		swireSet[`SW_SYNC_TOL_BIT]   = tolErr;
		swireSet[`SW_INVALID_BIT]    = swireCmdDone && !swireCmdValid;
		// Thresholds live in the analog comparators; here only their outputs are latched
		supplySet = '0;
		supplySet[`SUP_BRIDGE_HI_BIT] = bridgeSupplyHigh;
		supplySet[`SUP_BRIDGE_LO_BIT] = bridgeSupplyLow;
		supplySet[`SUP_REF_HI_BIT]    = referenceHigh;
		supplySet[`SUP_REF_LO_BIT]    = referenceLow;
		supplySet[`SUP_CORE_HI_BIT]   = coreSupplyHigh;
		supplySet[`SUP_CORE_LO_BIT]   = coreSupplyLow;
		frontCmp = {
			temperatureAmpOutLow, temperatureAmpOutHigh,
			pressureAmpOutLow, pressureAmpOutHigh,
			temperatureInputPosLow || temperatureInputNegLow,
			temperatureInputPosHigh || temperatureInputNegHigh,
			pressureInputPosLow || pressureInputNegLow,
			pressureInputPosHigh || pressureInputNegHigh
		};
		frontEnable = diagEnable_reg[`FRONT_W-1:0] |
			{`FRONT_W{diagEnable_reg[`FE_GLOBAL_BIT]}};
		frontSet = frontCmp & frontEnable;
	end

	// Bus decode; ack follows the request by one cycle and writes commit on the ack edge
	always_comb begin
		busHit  = wb_cyc_i && wb_stb_i;
		ackNext = busHit && !wb_ack_o;
		wrNow   = busHit && wb_we_i && wb_ack_o;
		wrMask  = byteMask(wb_sel_i) & {32{wrNow}};
		case (wb_adr_i)
			`REG_IFACE_ERR:  readWord = {{(32-`IFACE_W){1'b0}}, ifaceErr_reg};
			`REG_SWIRE_ERR:  readWord = {{(32-`SWIRE_W){1'b0}}, swireErr_reg};
			`REG_SUPPLY_MON: readWord = {{(32-`SUPPLY_W){1'b0}}, supplyMonitorFlags_reg};
			`REG_FRONT_DIAG: readWord = {{(32-`FRONT_W){1'b0}}, frontEndDiagFlags_reg};
			`REG_DIAG_EN:    readWord = {{(32-`DIAG_EN_W){1'b0}}, diagEnable_reg};
			default:         readWord = 32'h0000_0000; // Unmapped reads as zero
		endcase
		datNext = (ackNext && !wb_we_i) ? readWord : 32'h0000_0000;
	end

	// Sticky flags: any write clears every flag in its enabled bytes, whatever the data; a set in the same cycle wins
	always_comb begin
		ifaceErr_next = ifaceErr_reg | ifaceSet;
		swireErr_next = swireErr_reg | swireSet;
		supplyMonitorFlags_next = supplyMonitorFlags_reg | supplySet;
		frontEndDiagFlags_next  = frontEndDiagFlags_reg | frontSet;
		diagEnable_next = diagEnable_reg;
		case (wb_adr_i)
			`REG_IFACE_ERR: begin
				ifaceErr_next = (ifaceErr_reg & ~wrMask[`IFACE_W-1:0]) | ifaceSet;
			end
			`REG_SWIRE_ERR: begin
				swireErr_next = (swireErr_reg & ~wrMask[`SWIRE_W-1:0]) | swireSet;
			end
			`REG_SUPPLY_MON: begin
				supplyMonitorFlags_next =
					(supplyMonitorFlags_reg & ~wrMask[`SUPPLY_W-1:0]) | supplySet;
			end
			`REG_FRONT_DIAG: begin
				frontEndDiagFlags_next =
					(frontEndDiagFlags_reg & ~wrMask[`FRONT_W-1:0]) | frontSet;
			end
			`REG_DIAG_EN: begin
				diagEnable_next = (diagEnable_reg & ~wrMask[`DIAG_EN_W-1:0]) |
					(wb_dat_i[`DIAG_EN_W-1:0] & wrMask[`DIAG_EN_W-1:0]);
			end
			default: begin
			end
		endcase
		anyNext = (|ifaceErr_reg) || (|swireErr_reg) || (|supplyMonitorFlags_reg) ||
			(|frontEndDiagFlags_reg);
	end

	// Register file and bus outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ifaceErr_reg           <= '0;
			swireErr_reg           <= '0;
			supplyMonitorFlags_reg <= '0;
			frontEndDiagFlags_reg  <= '0;
			diagEnable_reg         <= `DIAG_EN_RESET;
			wb_ack_o               <= 1'b0;
			wb_dat_o               <= 32'h0000_0000;
			anyFault               <= 1'b0;
		end else begin
			ifaceErr_reg           <= ifaceErr_next;
			swireErr_reg           <= swireErr_next;
			supplyMonitorFlags_reg <= supplyMonitorFlags_next;
			frontEndDiagFlags_reg  <= frontEndDiagFlags_next;
			diagEnable_reg         <= diagEnable_next;
			wb_ack_o               <= ackNext;
			wb_dat_o               <= datNext;
			anyFault               <= anyNext;
		end
	end

	a_i2c_err_flag: assert property (@(posedge clock) disable iff (!rst_n)
		i2cErrResp |=> ifaceErr_reg[`IFACE_I2C_BIT]) else $error("i2c error not flagged");
	a_swire_err_flag: assert property (@(posedge clock) disable iff (!rst_n)
		swireErrResp |=> ifaceErr_reg[`IFACE_SWIRE_BIT])
		else $error("single-wire access error not flagged");
	a_trace_err_flag: assert property (@(posedge clock) disable iff (!rst_n)
		traceErrResp |=> ifaceErr_reg[`IFACE_TRACE_BIT]) else $error("trace error not flagged");
	a_slow_to_flag: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(slowErr) |-> ##1 swireErr_reg[`SW_SYNC_SLOW_BIT])
		else $error("slow sync not flagged");
	a_fast_to_flag: assert property (@(posedge clock) disable iff (!rst_n)
		fastErr |=> swireErr_reg[`SW_SYNC_FAST_BIT]) else $error("fast sync not flagged");
	a_override_flag: assert property (@(posedge clock) disable iff (!rst_n)
		(swirePhase == sensor_fault_pkg::PH_DATA_STOP && swireDeviceTx && !swireLine)
		|-> ##[1:2] swireErr_reg[`SW_DATA_OVER_BIT]) else $error("overdrive not flagged");
	a_invalid_cmd: assert property (@(posedge clock) disable iff (!rst_n)
		(swireCmdDone && !swireCmdValid) |=> swireErr_reg[`SW_INVALID_BIT])
		else $error("invalid command not flagged");
	a_bridge_low: assert property (@(posedge clock) disable iff (!rst_n)
		bridgeSupplyLow |=> supplyMonitorFlags_reg[`SUP_BRIDGE_LO_BIT])
		else $error("bridge low not latched");
	a_pin_either: assert property (@(posedge clock) disable iff (!rst_n)
		(pressureInputNegHigh && frontEnable[0]) |=> frontEndDiagFlags_reg[0])
		else $error("negative pin overvoltage missed");
	a_diag_gated: assert property (@(posedge clock) disable iff (!rst_n)
		(frontEnable[2] == 1'b0) |=> !$rose(frontEndDiagFlags_reg[2]))
		else $error("disabled diagnostic updated");
	a_global_enable: assert property (@(posedge clock) disable iff (!rst_n)
		(diagEnable_reg[`FE_GLOBAL_BIT] && temperatureAmpOutLow) |=>
		frontEndDiagFlags_reg[7]) else $error("global enable ignored");
	a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		(swireErr_reg[`SW_SYNC_TOL_BIT] && !(wrNow && wb_adr_i == `REG_SWIRE_ERR))
		|=> swireErr_reg[`SW_SYNC_TOL_BIT]) else $error("flag dropped without clear");
	a_ack_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule // sensor_fault_status

// File: design/sensor_fault_defines.svh
`ifndef SENSOR_FAULT_DEFINES_SVH
`define SENSOR_FAULT_DEFINES_SVH

// Clock and link timing
`define CLOCK_HZ           250000000
`define SYNC_SLOW_BPS      320
`define SYNC_FAST_BPS      9600
`define SYNC_TOL_PCT       25
`define STOP_MIN_NS        104000
// Longest legal sync bit period, rounded down
`define SYNC_SLOW_CYCLES   (`CLOCK_HZ / `SYNC_SLOW_BPS)
// Shortest legal sync bit period, rounded up
`define SYNC_FAST_CYCLES   ((`CLOCK_HZ + `SYNC_FAST_BPS - 1) / `SYNC_FAST_BPS)
// Least stop bit duration, rounded up
`define STOP_MIN_CYCLES    ((`STOP_MIN_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)

// Register byte offsets
`define REG_IFACE_ERR      8'h00
`define REG_SWIRE_ERR      8'h04
`define REG_SUPPLY_MON     8'h08
`define REG_FRONT_DIAG     8'h0C
`define REG_DIAG_EN        8'h10

// Field widths
`define IFACE_W            3
`define SWIRE_W            10
`define SUPPLY_W           6
`define FRONT_W            8
`define DIAG_EN_W          9

// Access error fields
`define IFACE_I2C_BIT      0
`define IFACE_SWIRE_BIT    1
`define IFACE_TRACE_BIT    2

// Single-wire error fields
`define SW_SYNC_SLOW_BIT   0
`define SW_SYNC_FAST_BIT   1
`define SW_SYNC_SHORT_BIT  2
`define SW_CMD_BAD_BIT     3
`define SW_CMD_SHORT_BIT   4
`define SW_DATA_BAD_BIT    5
`define SW_DATA_SHORT_BIT  6
`define SW_DATA_OVER_BIT   7
`define SW_SYNC_TOL_BIT    8
`define SW_INVALID_BIT     9

// Supply monitor fields: bridge, reference, core supply (high, low)
`define SUP_BRIDGE_HI_BIT  0
`define SUP_BRIDGE_LO_BIT  1
`define SUP_REF_HI_BIT     2
`define SUP_REF_LO_BIT     3
`define SUP_CORE_HI_BIT    4
`define SUP_CORE_LO_BIT    5

// Front-end fields: pressure input, temperature input, pressure amp, temperature amp
`define FE_GLOBAL_BIT      8

// Reset values
`define DIAG_EN_RESET      9'h000

`endif

// File: design/sensor_fault_pkg.sv
package sensor_fault_pkg;

	// Frame phase reported by the single-wire receiver
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_SYNC,
		PH_SYNC_STOP,
		PH_CMD,
		PH_CMD_STOP,
		PH_DATA,
		PH_DATA_STOP
	} swire_phase_e;

	// Sync field measurement
	typedef enum logic {
		SYNC_WAIT,
		SYNC_MEASURE
	} sync_state_e;

endpackage // sensor_fault_pkg

// File: design/swire_if.sv
interface swire_if;
	logic                           lineLevel;
	sensor_fault_pkg::swire_phase_e phase;
	logic                           deviceTx;

	modport source (output lineLevel, output phase, output deviceTx);
	modport monitor (input lineLevel, input phase, input deviceTx);
endinterface // swire_if

// File: design/sync_rate_checker.sv
`include "sensor_fault_defines.svh"

module sync_rate_checker #(
	parameter int SLOW_CYCLES = `SYNC_SLOW_CYCLES,
	parameter int FAST_CYCLES = `SYNC_FAST_CYCLES,
	parameter int CNT_W       = 20
) (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst_n,
	// Link view
	swire_if.monitor   link,
	// Error pulses
	output logic       slowErr,
	output logic       fastErr,
	output logic       tolErr
);
	localparam logic [CNT_W-1:0] SLOW_LIM = CNT_W'(SLOW_CYCLES);
	localparam logic [CNT_W-1:0] FAST_LIM = CNT_W'(FAST_CYCLES);
	localparam logic [31:0]      TOL      = 32'(`SYNC_TOL_PCT);

	sensor_fault_pkg::sync_state_e state_reg, state_next;
	logic [CNT_W-1:0] count_reg, count_next, prev_reg, prev_next;
	logic             havePrev_reg, havePrev_next, lastLine_reg, lastLine_next;
	logic             slow_next, fast_next, tol_next;
	logic             lineEdge, inSync;
	logic [CNT_W-1:0] period, diff;

	// Each level change after the one that starts measuring closes one bit period; a silent line times out as too slow
	always_comb begin
		state_next    = state_reg;
		count_next    = count_reg;
		prev_next     = prev_reg;
		havePrev_next = havePrev_reg;
		lastLine_next = link.lineLevel;
		slow_next     = 1'b0;
		fast_next     = 1'b0;
		tol_next      = 1'b0;
		lineEdge      = link.lineLevel != lastLine_reg;
		inSync        = link.phase == sensor_fault_pkg::PH_SYNC;
		period        = count_reg + CNT_W'(1);
		diff          = (period > prev_reg) ? period - prev_reg : prev_reg - period;
		unique case (state_reg)
			sensor_fault_pkg::SYNC_WAIT: begin
				if (inSync && lineEdge) begin
					state_next    = sensor_fault_pkg::SYNC_MEASURE;
					count_next    = '0;
					havePrev_next = 1'b0;
				end
			end
			sensor_fault_pkg::SYNC_MEASURE: begin
				if (!inSync) begin
					state_next = sensor_fault_pkg::SYNC_WAIT;
				end else if (lineEdge) begin
					fast_next = period < FAST_LIM;
					// Widened to 32 bits so the percent products cannot wrap
					tol_next = havePrev_reg && (({12'h000, diff} * 32'd100) >
						({12'h000, prev_reg} * TOL));
					prev_next     = period;
					havePrev_next = 1'b1;
					count_next    = '0;
				end else begin
					// One sample past the longest legal period is already too slow
					slow_next = count_reg == SLOW_LIM - CNT_W'(1);
					if (count_reg <= SLOW_LIM) begin
						count_next = count_reg + CNT_W'(1);
					end
				end
			end
		endcase
	end

	// Measurement state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= sensor_fault_pkg::SYNC_WAIT;
			count_reg    <= '0;
			prev_reg     <= '0;
			havePrev_reg <= 1'b0;
			lastLine_reg <= 1'b1;
			slowErr      <= 1'b0;
			fastErr      <= 1'b0;
			tolErr       <= 1'b0;
		end else begin
			state_reg    <= state_next;
			count_reg    <= count_next;
			prev_reg     <= prev_next;
			havePrev_reg <= havePrev_next;
			lastLine_reg <= lastLine_next;
			slowErr      <= slow_next;
			fastErr      <= fast_next;
			tolErr       <= tol_next;
		end
	end

	a_slow_single_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		slowErr |=> !slowErr [*2]) else $error("slow sync flagged twice in a row");
endmodule // sync_rate_checker

// File: design/stop_bit_checker.sv
module stop_bit_checker #(
	parameter sensor_fault_pkg::swire_phase_e STOP_PHASE = sensor_fault_pkg::PH_SYNC_STOP,
	parameter int                             MIN_CYCLES = 26000,
	parameter int                             CNT_W      = 20
) (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst_n,
	// Link view
	swire_if.monitor   link,
	// Error pulses
	output logic       badLevel,
	output logic       shortStop,
	output logic       overdriven
);
	localparam logic [CNT_W-1:0] MIN_LIM = CNT_W'(MIN_CYCLES);

	logic             active, active_reg, badSeen_reg, badSeen_next, ovSeen_reg, ovSeen_next;
	logic             txSeen_reg, txSeen_next, bad_next, short_next, over_next;
	logic [CNT_W-1:0] count_reg, count_next;

	// Stop bit must stay recessive (high); counting stops at the limit
	always_comb begin
		active       = link.phase == STOP_PHASE;
		count_next   = count_reg;
		badSeen_next = badSeen_reg;
		ovSeen_next  = ovSeen_reg;
		txSeen_next  = txSeen_reg;
		bad_next     = 1'b0;
		short_next   = 1'b0;
		over_next    = 1'b0;
		if (active) begin
			if (!active_reg) begin
				count_next   = '0;
				badSeen_next = 1'b0;
				ovSeen_next  = 1'b0;
				txSeen_next  = 1'b0;
			end
			if (link.deviceTx) begin
				txSeen_next = 1'b1;
			end
			if (link.lineLevel && count_next < MIN_LIM) begin
				count_next = count_next + CNT_W'(1);
			end
			// Low while the host sends is a bad level; low while we send is overdrive
			if (!link.lineLevel && !link.deviceTx && !badSeen_next) begin
				bad_next     = 1'b1;
				badSeen_next = 1'b1;
			end
			if (!link.lineLevel && link.deviceTx && !ovSeen_next) begin
				over_next   = 1'b1;
				ovSeen_next = 1'b1;
			end
		end else if (active_reg) begin
			short_next = !txSeen_reg && count_reg < MIN_LIM;
		end
	end

	// Stop bit state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			active_reg  <= 1'b0;
			count_reg   <= '0;
			badSeen_reg <= 1'b0;
			ovSeen_reg  <= 1'b0;
			txSeen_reg  <= 1'b0;
			badLevel    <= 1'b0;
			shortStop   <= 1'b0;
			overdriven  <= 1'b0;
		end else begin
			active_reg  <= active;
			count_reg   <= count_next;
			badSeen_reg <= badSeen_next;
			ovSeen_reg  <= ovSeen_next;
			txSeen_reg  <= txSeen_next;
			badLevel    <= bad_next;
			shortStop   <= short_next;
			overdriven  <= over_next;
		end
	end

	a_full_stop_ok: assert property (@(posedge clock) disable iff (!rst_n)
		(active_reg && !active && count_reg == MIN_LIM) |=> !shortStop)
		else $error("full length stop bit reported short");
endmodule // stop_bit_checker

// File: verification/host_link_model.sv
// Host end of the single-wire link; the line idles recessive through its pull-up
module host_link_model (
	// Clock
	input  wire logic                      clock,
	// Link view
	output logic                           line,
	output sensor_fault_pkg::swire_phase_e phase,
	output logic                           deviceTx
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released line reads recessive
	initial begin
		line     = 1'b1;
		phase    = sensor_fault_pkg::PH_IDLE;
		deviceTx = 1'b0;
	end

	// Falling edge opens the field, two bit periods follow; phase ends before the line rises
	task automatic sync_field(input int p1, input int p2);
		@(posedge clock);
		phase <= sensor_fault_pkg::PH_SYNC;
		line  <= 1'b0;
		repeat (p1) @(posedge clock);
		line <= 1'b1;
		repeat (p2) @(posedge clock);
		line <= 1'b0;
		repeat (4) @(posedge clock);
		phase <= sensor_fault_pkg::PH_IDLE;
		@(posedge clock);
		line <= 1'b1;
	endtask

	// Stop bit at a chosen level and length; tx marks the device as sender
	task automatic stop_bit(input sensor_fault_pkg::swire_phase_e ph, input logic lvl,
		input logic tx, input int n);
		@(posedge clock);
		phase    <= ph;
		line     <= lvl;
		deviceTx <= tx;
		repeat (n) @(posedge clock);
		phase    <= sensor_fault_pkg::PH_IDLE;
		line     <= 1'b1;
		deviceTx <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule // host_link_model

// File: verification/sensor_fault_status_tb.sv
module sensor_fault_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		sensor_fault_pkg::swire_phase_e ph;
		logic lvl, tx;
		int n;
		logic [9:0] e;
	} stop_s;
	logic        clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] datIn = 32'h0, datOut, rd;
	logic        ack, anyFault, line, txOn, cmdDone = 1'b0, cmdValid = 1'b0;
	logic [20:0] flagIn = '0;
	sensor_fault_pkg::swire_phase_e phase;
	int          fail_count = 0, total_checks = 0;
	// Register in the high byte, expected flag in the low byte, one row per event input
	logic [15:0] rows [21] = '{16'h0001, 16'h0002, 16'h0004, 16'h0801, 16'h0802, 16'h0804,
		16'h0808, 16'h0810, 16'h0820, 16'h0C01, 16'h0C01, 16'h0C02, 16'h0C02, 16'h0C04,
		16'h0C04, 16'h0C08, 16'h0C08, 16'h0C10, 16'h0C20, 16'h0C40, 16'h0C80};
	int          p1s [7] = '{19, 20, 250, 40, 40, 200, 201};
	int          p2s [7] = '{19, 20, 250, 50, 51, 200, 201};
	logic [9:0]  sExp [7] = '{10'h002, 10'h000, 10'h001, 10'h000, 10'h100, 10'h000, 10'h001};
	stop_s       stops [6] = '{'{sensor_fault_pkg::PH_SYNC_STOP, 1'b1, 1'b0, 5, 10'h004},
		'{sensor_fault_pkg::PH_CMD_STOP, 1'b0, 1'b0, 12, 10'h018},
		'{sensor_fault_pkg::PH_CMD_STOP, 1'b1, 1'b0, 5, 10'h010},
		'{sensor_fault_pkg::PH_DATA_STOP, 1'b0, 1'b0, 12, 10'h060},
		'{sensor_fault_pkg::PH_DATA_STOP, 1'b0, 1'b1, 12, 10'h080},
		'{sensor_fault_pkg::PH_SYNC_STOP, 1'b1, 1'b0, 10, 10'h000}};

	// Short counts keep the slow-sync wait within the run
	sensor_fault_status #(.SYNC_SLOW_CYCLES(200), .SYNC_FAST_CYCLES(20), .STOP_MIN_CYCLES(10))
	sensor_fault_status_inst (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datIn), .wb_dat_o(datOut),
		.wb_ack_o(ack), .i2cErrResp(flagIn[0]), .swireErrResp(flagIn[1]),
		.traceErrResp(flagIn[2]), .swireLine(line), .swirePhase(phase), .swireDeviceTx(txOn),
		.swireCmdDone(cmdDone), .swireCmdValid(cmdValid), .bridgeSupplyHigh(flagIn[3]),
		.bridgeSupplyLow(flagIn[4]), .referenceHigh(flagIn[5]), .referenceLow(flagIn[6]),
		.coreSupplyHigh(flagIn[7]), .coreSupplyLow(flagIn[8]),
		.pressureInputPosHigh(flagIn[9]), .pressureInputNegHigh(flagIn[10]),
		.pressureInputPosLow(flagIn[11]), .pressureInputNegLow(flagIn[12]),
		.temperatureInputPosHigh(flagIn[13]), .temperatureInputNegHigh(flagIn[14]),
		.temperatureInputPosLow(flagIn[15]), .temperatureInputNegLow(flagIn[16]),
		.pressureAmpOutHigh(flagIn[17]), .pressureAmpOutLow(flagIn[18]),
		.temperatureAmpOutHigh(flagIn[19]), .temperatureAmpOutLow(flagIn[20]),
		.anyFault(anyFault));
	host_link_model host_link_model_inst (.clock(clock), .line(line), .phase(phase),
		.deviceTx(txOn));

	// 250 MHz clock
	always #2 clock = ~clock;

	// Classic single cycle; the request holds until ack is seen at an edge
	task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, datIn} <= {2'b11, w, a, d};
		do @(posedge clock); while (ack !== 1'b1);
		rd = datOut;
		{cyc, stb} <= 2'b00;
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		wbx(1'b0, a, 32'h0);
		total_checks++;
		if (rd !== e || ack !== 1'b1) begin
			fail_count++;
			$display("ERROR reg %h expected %h seen %h", a, e, rd);
		end
	endtask

	task automatic cmp1(input string n, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", n, e, s);
		end
	endtask

	// One-cycle event, then time for the flag to land
	task automatic pulse(input int i);
		@(posedge clock);
		flagIn[i] <= 1'b1;
		@(posedge clock);
		flagIn[i] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task automatic stop_test();
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		chk(8'h10, 32'h0);
		chk(8'h20, 32'h0);
		pulse(13);
		chk(8'h0C, 32'h0);
		wbx(1'b1, 8'h10, 32'h10);
		pulse(17);
		pulse(20);
		chk(8'h0C, 32'h10);
		wbx(1'b1, 8'h0C, 32'h10);
		wbx(1'b1, 8'h10, 32'h100);
		for (int i = 0; i < 21; i++) begin
			pulse(i);
			chk(rows[i][15:8], {24'h0, rows[i][7:0]});
			cmp1("anyFault", 1'b1, anyFault);
			wbx(1'b1, rows[i][15:8], {24'h0, rows[i][7:0]});
			chk(rows[i][15:8], 32'h0);
			cmp1("anyFault", 1'b0, anyFault);
		end
		@(posedge clock);
		{cmdDone, cmdValid} <= 2'b10;
		@(posedge clock);
		cmdDone <= 1'b0;
		repeat (3) @(posedge clock);
		chk(8'h04, 32'h200);
		wbx(1'b1, 8'h04, 32'h3FF);
		for (int i = 0; i < 7; i++) begin
			host_link_model_inst.sync_field(p1s[i], p2s[i]);
			chk(8'h04, {22'h0, sExp[i]});
			wbx(1'b1, 8'h04, 32'h3FF);
		end
		foreach (stops[i]) begin
			host_link_model_inst.stop_bit(stops[i].ph, stops[i].lvl, stops[i].tx, stops[i].n);
			chk(8'h04, {22'h0, stops[i].e});
			wbx(1'b1, 8'h04, 32'h3FF);
		end
		stop_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule // sensor_fault_status_tb
